// >>> include/adc_consts.vh
`ifndef ADC_CONSTS_VH
`define ADC_CONSTS_VH

// register indices; byte address on the bus is four times the index
`define IDX_CONTROL      12'hF70
`define IDX_RESULT_UPPER 12'hF72
`define IDX_RESULT_LOWER 12'hF73
`define IDX_STATUS       12'hF74

// converter_control fields
`define CTL_GO_BIT       7
`define CTL_RSVD_BIT     6
`define CTL_REF_BIT      5
`define CTL_REPEAT_BIT   4
`define CTL_CH_MSB       3
`define CTL_CH_LSB       0
`define CTL_RESET        8'h00

// status fields
`define STAT_BUSY_BIT    0
`define STAT_POWER_BIT   1
`define STAT_REPEAT_BIT  2
`define STAT_DMA_BIT     3
`define STAT_CH_MSB      7
`define STAT_CH_LSB      4

// channel range
`define CH_LAST          4'hB
`define CH_COUNT         12

// timing in system clock cycles
`define CYC_IDLE_DOWN    13'h00A0
`define CYC_WAKE         13'h0028
`define CYC_CONVERT      13'h1409
`define CYC_REPEAT       13'h0100

`endif

// >>> verilog/result_ram.v
`timescale 1ns/100ps
`include "adc_consts.vh"

// per-channel result store, read as two bytes per channel
module result_ram (
	// clock
	input  wire       clk,
	input  wire       rst_n,
	// write side, one whole result per write
	input  wire       wr_en,
	input  wire [3:0] wr_idx,
	input  wire [9:0] wr_data,
	// byte read side
	input  wire [4:0] rd_addr,
	output reg  [7:0] rd_data_ff
);

	reg [9:0] mem [0:`CH_COUNT-1];
	wire [9:0] word = (rd_addr[4:1] <= `CH_LAST) ? mem[rd_addr[4:1]] : 10'h000;

	always @(posedge clk) begin
		if (wr_en && wr_idx <= `CH_LAST) begin
			mem[wr_idx] <= wr_data;
		end
	end

	// even byte carries the upper eight bits, odd byte the two low bits
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_ff <= 8'h00;
		end else if (rd_addr[0]) begin
			rd_data_ff <= {word[1:0], 6'h00};
		end else begin
			rd_data_ff <= word[9:2];
		end
	end

endmodule

// >>> verilog/adc_conversion_sequencer.v
`timescale 1ns/100ps
`include "adc_consts.vh"

module adc_conversion_sequencer (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [15:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata_ff,
	output wire        pready,
	output wire        pslverr,
	// converter core
	input  wire [9:0]  conv_data,
	output wire        conv_power_on,
	output wire        conv_run,
	output wire        ref_int_en,
	output reg  [3:0]  mux_sel_ff,
	// interrupt controller
	output reg         conv_irq_ff,
	// dma controller
	input  wire        dma_enable,
	input  wire [3:0]  dma_last_ch,
	input  wire [4:0]  dma_rd_addr,
	output wire [7:0]  dma_rd_data,
	output reg         dma_result_ready_ff,
	output reg  [3:0]  dma_result_ch_ff,
	output reg         dma_seq_done_ff
);

	localparam ST_DOWN = 5'b00001;
	localparam ST_WAKE = 5'b00010;
	localparam ST_CONV = 5'b00100;
	localparam ST_RPT  = 5'b01000;
	localparam ST_IDLE = 5'b10000;

	// true when the apb address selects the word at index idx
	function hit;
		input [15:0] addr;
		input [11:0] idx;
		begin
			hit = (addr == {2'b00, idx, 2'b00});
		end
	endfunction

	// wrap-around step through the dma sequence
	function [3:0] next_ch;
		input [3:0] cur;
		input [3:0] last;
		begin
			if (cur >= last || cur >= `CH_LAST) begin
				next_ch = 4'h0;
			end else begin
				next_ch = cur + 4'h1;
			end
		end
	endfunction

	reg  [4:0]  state_ff;
	reg  [4:0]  nxt_state;
	reg  [12:0] cnt_ff;
	reg  [12:0] nxt_cnt;
	reg         go_ff;
	reg         rsvd_ff;
	reg         ref_ext_ff;
	reg         repeat_ff;
	reg  [3:0]  ch_field_ff;
	reg  [9:0]  result_ff;
	reg         dma_en_d_ff;
	reg  [3:0]  nxt_mux;
	reg         chain;

	// apb decode
	wire setup     = psel & ~penable;
	wire access    = psel & penable;
	wire wr_access = access & pwrite;
	wire hit_ctl   = hit(paddr, `IDX_CONTROL);
	wire hit_upper = hit(paddr, `IDX_RESULT_UPPER);
	wire hit_lower = hit(paddr, `IDX_RESULT_LOWER);
	wire hit_stat  = hit(paddr, `IDX_STATUS);
	wire mapped    = hit_ctl | hit_upper | hit_lower | hit_stat;
	wire ctl_wr    = wr_access & hit_ctl;

	// the register file always answers in the first access cycle
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	// while the dma owns the converter, software starts are ignored
	wire sw_go     = ctl_wr & pwdata[`CTL_GO_BIT] & ~dma_enable;
	wire dma_kick  = dma_enable & ~dma_en_d_ff;
	wire start_req = sw_go | dma_kick;

	wire cnt_zero  = (cnt_ff == 13'h0000);
	wire conv_done = state_ff[2] & cnt_zero & ~start_req;
	wire rpt_tick  = state_ff[3] & cnt_zero & repeat_ff & ~dma_enable
		& ~start_req;

	assign conv_power_on = ~state_ff[0];
	assign conv_run      = state_ff[2] | state_ff[3];
	assign ref_int_en    = ~ref_ext_ff;

	// sequencer next state; one down-counter serves every timed phase
	always @* begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		chain     = 1'b0;
		case (state_ff)
		ST_DOWN: begin
			if (start_req) begin
				nxt_state = ST_WAKE;
				nxt_cnt   = `CYC_WAKE - 13'h0001;
			end
		end
		ST_WAKE: begin
			// a repeated start during power-up does not shorten it
			if (cnt_zero) begin
				nxt_state = ST_CONV;
				nxt_cnt   = `CYC_CONVERT - 13'h0001;
			end else begin
				nxt_cnt = cnt_ff - 13'h0001;
			end
		end
		ST_CONV: begin
			if (start_req) begin
				nxt_cnt = `CYC_CONVERT - 13'h0001;
			end else if (cnt_zero) begin
				if (dma_enable) begin
					chain   = 1'b1;
					nxt_cnt = `CYC_CONVERT - 13'h0001;
				end else if (repeat_ff) begin
					nxt_state = ST_RPT;
					nxt_cnt   = `CYC_REPEAT - 13'h0001;
				end else begin
					nxt_state = ST_IDLE;
					nxt_cnt   = `CYC_IDLE_DOWN - 13'h0001;
				end
			end else begin
				nxt_cnt = cnt_ff - 13'h0001;
			end
		end
		ST_RPT: begin
			if (start_req) begin
				nxt_state = ST_CONV;
				nxt_cnt   = `CYC_CONVERT - 13'h0001;
			end else if (!repeat_ff || dma_enable) begin
				nxt_state = ST_IDLE;
				nxt_cnt   = `CYC_IDLE_DOWN - 13'h0001;
			end else if (cnt_zero) begin
				nxt_cnt = `CYC_REPEAT - 13'h0001;
			end else begin
				nxt_cnt = cnt_ff - 13'h0001;
			end
		end
		ST_IDLE: begin
			if (start_req) begin
				nxt_state = ST_CONV;
				nxt_cnt   = `CYC_CONVERT - 13'h0001;
			end else if (cnt_zero) begin
				nxt_state = ST_DOWN;
			end else begin
				nxt_cnt = cnt_ff - 13'h0001;
			end
		end
		default: begin
			nxt_state = ST_DOWN;
			nxt_cnt   = 13'h0000;
		end
		endcase
	end

	// channel steering: dma walks from input 0, software uses the field
	always @* begin
		nxt_mux = mux_sel_ff;
		if (dma_kick) begin
			nxt_mux = 4'h0;
		end else if (chain) begin
			nxt_mux = next_ch(mux_sel_ff, dma_last_ch);
		end else if (ctl_wr && !dma_enable) begin
			nxt_mux = pwdata[`CTL_CH_MSB:`CTL_CH_LSB];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff    <= ST_DOWN;
			cnt_ff      <= 13'h0000;
			dma_en_d_ff <= 1'b0;
			mux_sel_ff  <= 4'h0;
		end else begin
			state_ff    <= nxt_state;
			cnt_ff      <= nxt_cnt;
			dma_en_d_ff <= dma_enable;
			mux_sel_ff  <= nxt_mux;
		end
	end

	// control register; the go bit is cleared only by completion and a
	// start in the completing cycle wins so the new request is kept
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_ff       <= 1'b0;
			rsvd_ff     <= 1'b0;
			ref_ext_ff  <= 1'b0;
			repeat_ff   <= 1'b0;
			ch_field_ff <= 4'h0;
		end else begin
			if (ctl_wr) begin
				rsvd_ff     <= pwdata[`CTL_RSVD_BIT];
				ref_ext_ff  <= pwdata[`CTL_REF_BIT];
				repeat_ff   <= pwdata[`CTL_REPEAT_BIT];
				ch_field_ff <= pwdata[`CTL_CH_MSB:`CTL_CH_LSB];
			end
			if (start_req || chain) begin
				go_ff <= 1'b1;
			end else if (conv_done) begin
				go_ff <= 1'b0;
			end
		end
	end

	// result capture, first conversion and every repeat period
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_ff <= 10'h000;
		end else if (conv_done || rpt_tick) begin
			result_ff <= conv_data;
		end
	end

	// only the first completion of a software run raises the request;
	// repeat periods never pass through conv_done
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_irq_ff <= 1'b0;
		end else begin
			conv_irq_ff <= conv_done & ~dma_enable;
		end
	end

	// dma hand-off: each finished channel lands in the result image
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_result_ready_ff <= 1'b0;
			dma_result_ch_ff    <= 4'h0;
			dma_seq_done_ff     <= 1'b0;
		end else begin
			dma_result_ready_ff <= conv_done & dma_enable;
			if (conv_done && dma_enable) begin
				dma_result_ch_ff <= mux_sel_ff;
			end
			dma_seq_done_ff <= conv_done & dma_enable
				& (next_ch(mux_sel_ff, dma_last_ch) == 4'h0);
		end
	end

	result_ram u_result_ram (
		.clk        (pclk),
		.rst_n      (presetn),
		.wr_en      (conv_done & dma_enable),
		.wr_idx     (mux_sel_ff),
		.wr_data    (conv_data),
		.rd_addr    (dma_rd_addr),
		.rd_data_ff (dma_rd_data)
	);

	// read data is latched in the setup cycle so it stands in the access
	// cycle from a flip-flop; reserved low result bits read as zero
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h00000000;
		end else if (setup && !pwrite) begin
			if (hit_ctl) begin
				prdata_ff <= {24'h000000, go_ff, rsvd_ff, ref_ext_ff,
					repeat_ff, ch_field_ff};
			end else if (hit_upper) begin
				prdata_ff <= {24'h000000, result_ff[9:2]};
			end else if (hit_lower) begin
				prdata_ff <= {24'h000000, result_ff[1:0], 6'h00};
			end else if (hit_stat) begin
				prdata_ff <= {24'h000000, mux_sel_ff, dma_enable,
					state_ff[3], conv_power_on, conv_run};
			end else begin
				prdata_ff <= 32'h00000000;
			end
		end
	end

endmodule

// >>> dv/conv_model.sv
`timescale 1ns/100ps
module conv_model (
	// converter control
	input  logic       conv_run,
	input  logic [9:0] level,
	// filter output
	output logic [9:0] conv_data
);
	// outside a conversion the filter output is not valid: show the inverse
	// so a result captured at the wrong moment cannot match by chance
	assign conv_data = conv_run ? level : ~level;
endmodule

// >>> dv/adc_seq_properties.sv
`timescale 1ns/100ps
module adc_seq_properties (
	// clock and reset
	input logic        pclk,
	input logic        presetn,
	// apb
	input logic        psel,
	input logic        penable,
	input logic [15:0] paddr,
	input logic [31:0] prdata_ff,
	input logic        pslverr,
	// converter and dma
	input logic        conv_power_on,
	input logic        conv_run,
	input logic        conv_irq_ff,
	input logic [3:0]  dma_last_ch,
	input logic        dma_result_ready_ff,
	input logic [3:0]  dma_result_ch_ff,
	input logic        dma_seq_done_ff
);
	logic [12:0] run_ff;
	logic [8:0]  idle_ff;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// counts saturate so a long repeat run never wraps to a short one
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_ff <= 13'h0;
			idle_ff <= 9'h0;
		end else begin
			run_ff <= conv_run ? run_ff + {12'h0, ~&run_ff} : 13'h0;
			idle_ff <= (conv_run | ~conv_power_on) ? 9'h0 :
				idle_ff + {8'h0, ~&idle_ff};
		end
	end
	pslverr_map_a: assert property (psel && penable |-> pslverr ==
		!(paddr inside {16'h3DC0, 16'h3DC8, 16'h3DCC, 16'h3DD0}))
		else $error("pslverr does not match the address map");
	prdata_hi_a: assert property (prdata_ff[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	run_len_a: assert property ($fell(conv_run) |-> run_ff >= 13'h1400)
		else $error("conversion ended early");
	wake_time_a: assert property ($rose(conv_power_on) |->
		!conv_run [*8] ##[31:34] conv_run)
		else $error("power-up time wrong");
	idle_down_a: assert property ($fell(conv_power_on) |->
		idle_ff >= 9'h09E && idle_ff <= 9'h0A2)
		else $error("power-down after wrong idle time");
	irq_once_a: assert property (conv_irq_ff |=> !conv_irq_ff)
		else $error("interrupt request longer than one cycle");
	irq_cause_a: assert property (conv_irq_ff |->
		$past(run_ff) >= 13'h1400)
		else $error("interrupt without a finished conversion");
	seq_done_a: assert property (dma_seq_done_ff |->
		dma_result_ready_ff && dma_result_ch_ff == dma_last_ch)
		else $error("sequence end on wrong channel");
	dma_gap_a: assert property (dma_result_ready_ff |=>
		!dma_result_ready_ff [*8])
		else $error("dma results too close together");
endmodule

// >>> dv/adc_conversion_sequencer_tb.sv
`timescale 1ns/100ps
module adc_conversion_sequencer_tb;
	localparam logic [15:0] a_ctl = 16'h3DC0;
	localparam logic [15:0] a_upr = 16'h3DC8;
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0;
	logic        dma_enable = 1'h0;
	logic [3:0]  dma_last_ch = 4'h0;
	logic [4:0]  dma_rd_addr = 5'h0;
	logic [9:0]  level = 10'h0;
	logic [31:0] prdata_ff, rd;
	logic [9:0]  conv_data;
	logic [7:0]  dma_rd_data;
	logic [3:0]  mux_sel_ff, dma_result_ch_ff;
	logic        pready, pslverr, err, conv_power_on, conv_run, ref_int_en;
	logic        conv_irq_ff, dma_result_ready_ff, dma_seq_done_ff;
	int          n_mismatch = 0, checked = 0, cyc = 0, n_irq = 0, t0;

	adc_conversion_sequencer i_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata_ff, .pready, .pslverr, .conv_data,
		.conv_power_on, .conv_run, .ref_int_en, .mux_sel_ff, .conv_irq_ff,
		.dma_enable, .dma_last_ch, .dma_rd_addr, .dma_rd_data,
		.dma_result_ready_ff, .dma_result_ch_ff, .dma_seq_done_ff);
	conv_model i_model (.conv_run, .level, .conv_data);

	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (conv_irq_ff === 1'h1)
			n_irq <= n_irq + 1;
	end

	task automatic test_done;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(logic wr, logic [15:0] a, logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'h1)
				break;
		end
		rd = prdata_ff;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// a bus that never answers ends the run here
		if (i == 20) begin
			n_mismatch++;
			test_done;
		end
	endtask

	// waits for the interrupt pulse, or for the dma sequence end
	task automatic wt(logic dma);
		for (int i = 0; i < 12000; i++) begin
			@(posedge pclk);
			if ((dma ? dma_seq_done_ff : conv_irq_ff) === 1'h1)
				return;
		end
		n_mismatch++;
		test_done;
	endtask

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, a_ctl, 32'h0);
		chk("ctl", 32'h0, rd);
		chk("ref", 32'h1, ref_int_en);
		chk("pwr", 32'h0, conv_power_on);
		level <= 10'h2C9;
		apb(1'h1, a_ctl, 32'hA3);
		apb(1'h1, a_ctl, 32'h23);
		apb(1'h0, a_ctl, 32'h0);
		chk("go", 32'hA3, rd);
		chk("ref", 32'h0, ref_int_en);
		chk("mux", 32'h3, mux_sel_ff);
		repeat (900) @(posedge pclk);
		apb(1'h1, a_ctl, 32'hA3);
		t0 = cyc;
		wt(1'h0);
		chk("restart", 32'h1, cyc - t0 > 5128 && cyc - t0 < 5140);
		apb(1'h0, a_ctl, 32'h0);
		chk("done", 32'h23, rd);
		apb(1'h1, a_upr, 32'hFF);
		apb(1'h0, a_upr, 32'h0);
		chk("upper", 32'hB2, rd);
		apb(1'h0, 16'h3DCC, 32'h0);
		chk("lower", 32'h40, rd & 32'hC0);
		apb(1'h0, 16'h3E00, 32'h0);
		chk("unmapped", 32'h1, err);
		repeat (170) @(posedge pclk);
		chk("pwr", 32'h0, conv_power_on);
		$display("single-shot test finished");
		level <= 10'h155;
		apb(1'h1, a_ctl, 32'h95);
		@(posedge pclk);
		chk("wake", 32'h1, conv_power_on);
		wt(1'h0);
		apb(1'h0, a_ctl, 32'h0);
		chk("go0", 32'h15, rd);
		// status: channel 5, no dma, repeat active, powered, running
		apb(1'h0, 16'h3DD0, 32'h0);
		chk("status", 32'h57, rd);
		t0 = n_irq;
		level <= 10'h0AA;
		repeat (600) @(posedge pclk);
		apb(1'h0, a_upr, 32'h0);
		chk("refresh", 32'h2A, rd);
		chk("irq", 32'h0, n_irq - t0);
		apb(1'h1, a_ctl, 32'h05);
		level <= 10'h3FF;
		repeat (300) @(posedge pclk);
		apb(1'h0, a_upr, 32'h0);
		chk("stopped", 32'h2A, rd);
		$display("repeat test finished");
		dma_last_ch <= 4'h1;
		dma_enable <= 1'h1;
		level <= 10'h1E7;
		repeat (3) @(posedge pclk);
		chk("dma_ch0", 32'h0, mux_sel_ff);
		wt(1'h1);
		dma_enable <= 1'h0;
		for (int a = 0; a < 4; a++) begin
			dma_rd_addr <= a[4:0];
			repeat (2) @(posedge pclk);
			chk("dma_byte", a[0] ? 32'hC0 : 32'h79, dma_rd_data);
		end
		$display("dma test finished");
		test_done;
	end
endmodule

bind adc_conversion_sequencer adc_seq_properties i_props (.pclk, .presetn,
	.psel, .penable, .paddr, .prdata_ff, .pslverr, .conv_power_on,
	.conv_run, .conv_irq_ff, .dma_last_ch, .dma_result_ready_ff,
	.dma_result_ch_ff, .dma_seq_done_ff);
